// file: rtl/eel_pkg.sv
package eel_pkg;

	// ========================================================================
	// geometry
	localparam int unsigned EEL_LINES = 24;   // all edge-detector lines
	localparam int unsigned EEL_EXT   = 16;   // lines fed from pins
	localparam int unsigned EEL_INT   = 8;    // lines fed from peripherals
	localparam int unsigned EEL_PINS  = 55;   // selectable pins
	localparam int unsigned EEL_SELW  = 6;    // width of one pin selector

	// ========================================================================
	// register map, byte addresses
	localparam logic [7:0] EEL_OFS_IMR  = 8'h00; // interrupt mask, 1 = on
	localparam logic [7:0] EEL_OFS_EMR  = 8'h04; // event mask, 1 = on
	localparam logic [7:0] EEL_OFS_RTSR = 8'h08; // rising trigger select
	localparam logic [7:0] EEL_OFS_FTSR = 8'h0C; // falling trigger select
	localparam logic [7:0] EEL_OFS_SWTR = 8'h10; // software trigger, w1
	localparam logic [7:0] EEL_OFS_PEND = 8'h14; // pending, write 1 clears
	localparam logic [7:0] EEL_OFS_SEL0 = 8'h18; // pin selectors 0..3
	localparam logic [7:0] EEL_OFS_STEP = 8'h04; // spacing of selector regs

	// ========================================================================
	// field layout of the selector registers
	localparam int unsigned EEL_SEL_STRIDE  = 8;  // bits per selector field
	localparam int unsigned EEL_SEL_PER_REG = 4;  // selectors per register
	localparam int unsigned EEL_SEL_REGS    = 4;  // selector registers

	// ========================================================================
	// reset values
	localparam logic [23:0] EEL_RST_MASK = 24'h00_0000;
	localparam logic [23:0] EEL_RST_TRIG = 24'h00_0000;
	localparam logic [31:0] EEL_RST_DATA = 32'h0000_0000;

	// register port request
	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} eel_req_t;

	// requests towards the system
	typedef struct packed {
		logic [EEL_LINES-1:0] irq;  // level per line
		logic [EEL_LINES-1:0] evt;  // one-cycle pulse per line
		logic                 wake; // one-cycle pulse
	} eel_out_t;

endpackage : eel_pkg

// file: rtl/eel_edge_catch.sv
`timescale 1ns/10ps
module eel_edge_catch
	import eel_pkg::*;
(
	input  wire logic CORE_CLK,
	input  wire logic RST_B,
	input  wire logic PIN,
	output logic      RISE,
	output logic      FALL
);

	logic       rise_tgl;
	logic       fall_tgl;
	logic [2:0] rise_sync;
	logic [2:0] fall_sync;
	logic       next_rise;
	logic       next_fall;

	// ========================================================================
	// pin-clocked toggles: a pulse shorter than a core period still flips them
	always_ff @(posedge PIN or negedge RST_B) begin
		if (!RST_B) begin
			rise_tgl <= 1'b0;
		end else begin
			rise_tgl <= ~rise_tgl;
		end
	end

	always_ff @(negedge PIN or negedge RST_B) begin
		if (!RST_B) begin
			fall_tgl <= 1'b0;
		end else begin
			fall_tgl <= ~fall_tgl;
		end
	end

	// ========================================================================
	// two-stage synchroniser plus one history stage; only stages 1 and 2
	// are compared, so stage 0 feeds nothing but stage 1.
	// limitation: two same-sense edges inside one sync window cancel out.
	always_comb begin
		next_rise = rise_sync[2] ^ rise_sync[1];
		next_fall = fall_sync[2] ^ fall_sync[1];
	end

	always_ff @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			rise_sync <= 3'h0;
			fall_sync <= 3'h0;
			RISE      <= 1'b0;
			FALL      <= 1'b0;
		end else begin
			rise_sync <= {rise_sync[1:0], rise_tgl};
			fall_sync <= {fall_sync[1:0], fall_tgl};
			RISE      <= next_rise;
			FALL      <= next_fall;
		end
	end

	// ========================================================================
	// checks
	a_catch_rise: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
		$changed(rise_tgl) |-> ##[1:5] RISE)
		else $error("rising toggle not reported");

endmodule : eel_edge_catch

// file: rtl/eel_pin_route.sv
`timescale 1ns/10ps
module eel_pin_route
	import eel_pkg::*;
#(
	parameter int unsigned N_PINS  = EEL_PINS,
	parameter int unsigned N_LINES = EEL_EXT,
	parameter int unsigned SEL_W   = EEL_SELW
)(
	input  wire logic                            CORE_CLK,
	input  wire logic                            RST_B,
	input  wire logic [N_PINS-1:0]               PIN_RISE,
	input  wire logic [N_PINS-1:0]               PIN_FALL,
	input  wire logic [N_LINES-1:0][SEL_W-1:0]   SEL,
	output logic      [N_LINES-1:0]              RISE,
	output logic      [N_LINES-1:0]              FALL
);

	logic [N_LINES-1:0] next_rise;
	logic [N_LINES-1:0] next_fall;

	// ========================================================================
	// per-line pin pick; a selector past the last pin routes nothing
	always_comb begin
		for (int j = 0; j < N_LINES; j++) begin
			next_rise[j] = 1'b0;
			next_fall[j] = 1'b0;
			if (SEL[j] < N_PINS) begin
				next_rise[j] = PIN_RISE[SEL[j]];
				next_fall[j] = PIN_FALL[SEL[j]];
			end
		end
	end

	always_ff @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			RISE <= '0;
			FALL <= '0;
		end else begin
			RISE <= next_rise;
			FALL <= next_fall;
		end
	end

	// ========================================================================
	// checks
	for (genvar j = 0; j < N_LINES; j++) begin : g_chk
		a_route_pick: assert property (@(posedge CORE_CLK)
			disable iff (!RST_B)
			(SEL[j] < N_PINS) |=> RISE[j] == $past(PIN_RISE[SEL[j]]))
			else $error("routed rise does not match selected pin");
		a_route_none: assert property (@(posedge CORE_CLK)
			disable iff (!RST_B)
			(SEL[j] >= N_PINS) |=> !RISE[j] && !FALL[j])
			else $error("out-of-range selector routed an edge");
	end

endmodule : eel_pin_route

// file: rtl/eel_extended_line_event_unit.sv
// Added by the designer: the address-and-strobe port and the placing of the registers.
`timescale 1ns/10ps
module eel_extended_line_event_unit
	import eel_pkg::*;
#(
	parameter int unsigned N_PINS = EEL_PINS
)(
	input  wire logic                CORE_CLK,
	input  wire logic                RST_B,
	input  wire eel_req_t            REQ,
	output logic      [31:0]         RD_DATA,
	input  wire logic [N_PINS-1:0]   PINS,
	input  wire logic [EEL_INT-1:0]  PERIPH_EVT,
	output eel_out_t                 OUT
);

	// ========================================================================
	// declarations
	logic [EEL_LINES-1:0]              imr;
	logic [EEL_LINES-1:0]              emr;
	logic [EEL_LINES-1:0]              rtsr;
	logic [EEL_LINES-1:0]              ftsr;
	logic [EEL_LINES-1:0]              pend;
	logic [EEL_LINES-1:0]              evt;
	logic                              wake;
	logic [EEL_EXT-1:0][EEL_SELW-1:0]  sel;
	logic [EEL_INT-1:0]                int_prev;
	logic [31:0]                       rd_data;

	logic [EEL_LINES-1:0]              next_imr;
	logic [EEL_LINES-1:0]              next_emr;
	logic [EEL_LINES-1:0]              next_rtsr;
	logic [EEL_LINES-1:0]              next_ftsr;
	logic [EEL_LINES-1:0]              next_pend;
	logic [EEL_LINES-1:0]              next_evt;
	logic                              next_wake;
	logic [EEL_EXT-1:0][EEL_SELW-1:0]  next_sel;
	logic [31:0]                       next_rd_data;

	logic [N_PINS-1:0]                 pin_rise;
	logic [N_PINS-1:0]                 pin_fall;
	logic [EEL_EXT-1:0]                ext_rise;
	logic [EEL_EXT-1:0]                ext_fall;
	logic [EEL_LINES-1:0]              line_rise;
	logic [EEL_LINES-1:0]              line_fall;
	logic [EEL_LINES-1:0]              trig;
	logic [EEL_LINES-1:0]              sw_trig;
	logic [EEL_LINES-1:0]              hit;
	logic [EEL_LINES-1:0]              pend_clr;

	// one write hitting a given register
	function automatic logic wr_hit(eel_req_t r, logic [7:0] ofs);
		return r.wr && (r.addr == ofs);
	endfunction : wr_hit

	// ========================================================================
	// pin side: one catcher per pin, so a selector change never glitches
	// a catcher clock; costs 55 catchers instead of 16
	for (genvar p = 0; p < N_PINS; p++) begin : g_pin
		eel_edge_catch u_catch (
			.CORE_CLK (CORE_CLK),
			.RST_B    (RST_B),
			.PIN      (PINS[p]),
			.RISE     (pin_rise[p]),
			.FALL     (pin_fall[p])
		);
	end

	eel_pin_route #(
		.N_PINS  (N_PINS),
		.N_LINES (EEL_EXT),
		.SEL_W   (EEL_SELW)
	) u_route (
		.CORE_CLK (CORE_CLK),
		.RST_B    (RST_B),
		.PIN_RISE (pin_rise),
		.PIN_FALL (pin_fall),
		.SEL      (sel),
		.RISE     (ext_rise),
		.FALL     (ext_fall)
	);

	// ========================================================================
	// edge qualification; peripheral lines share this clock, no sync needed
	always_comb begin
		line_rise = {PERIPH_EVT & ~int_prev, ext_rise};
		line_fall = {~PERIPH_EVT & int_prev, ext_fall};
		trig      = (line_rise & rtsr) | (line_fall & ftsr);
		sw_trig   = wr_hit(REQ, EEL_OFS_SWTR) ?
			REQ.wdata[EEL_LINES-1:0] : '0;
		hit       = trig | sw_trig;
		pend_clr  = wr_hit(REQ, EEL_OFS_PEND) ?
			REQ.wdata[EEL_LINES-1:0] : '0;
	end

	// ========================================================================
	// line state: pending, event pulse, wake pulse
	always_comb begin
		// set beats clear so an edge in the clearing cycle is kept
		next_pend = (pend & ~pend_clr) | (hit & imr);
		next_evt  = hit & emr;
		next_wake = |(hit & (imr | emr));
	end

	always_ff @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			pend     <= EEL_RST_MASK;
			evt      <= EEL_RST_MASK;
			wake     <= 1'b0;
			int_prev <= '0;
		end else begin
			pend     <= next_pend;
			evt      <= next_evt;
			wake     <= next_wake;
			int_prev <= PERIPH_EVT;
		end
	end

	// ========================================================================
	// configuration registers
	always_comb begin
		next_imr  = wr_hit(REQ, EEL_OFS_IMR) ?
			REQ.wdata[EEL_LINES-1:0] : imr;
		next_emr  = wr_hit(REQ, EEL_OFS_EMR) ?
			REQ.wdata[EEL_LINES-1:0] : emr;
		next_rtsr = wr_hit(REQ, EEL_OFS_RTSR) ?
			REQ.wdata[EEL_LINES-1:0] : rtsr;
		next_ftsr = wr_hit(REQ, EEL_OFS_FTSR) ?
			REQ.wdata[EEL_LINES-1:0] : ftsr;
		next_sel  = sel;
		for (int k = 0; k < EEL_SEL_REGS; k++) begin
			if (wr_hit(REQ, EEL_OFS_SEL0 + 8'(k) * EEL_OFS_STEP)) begin
				for (int m = 0; m < EEL_SEL_PER_REG; m++) begin
					next_sel[k*EEL_SEL_PER_REG+m] =
						REQ.wdata[m*EEL_SEL_STRIDE +: EEL_SELW];
				end
			end
		end
	end

	// selectors reset to line j = pin j
	always_ff @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			imr  <= EEL_RST_MASK;
			emr  <= EEL_RST_MASK;
			rtsr <= EEL_RST_TRIG;
			ftsr <= EEL_RST_TRIG;
			for (int j = 0; j < EEL_EXT; j++) begin
				sel[j] <= EEL_SELW'(j);
			end
		end else begin
			imr  <= next_imr;
			emr  <= next_emr;
			rtsr <= next_rtsr;
			ftsr <= next_ftsr;
			sel  <= next_sel;
		end
	end

	// ========================================================================
	// read port: data stands one cycle after the strobe, zero otherwise
	always_comb begin
		next_rd_data = EEL_RST_DATA;
		if (REQ.rd) begin
			case (REQ.addr)
				EEL_OFS_IMR:  next_rd_data[EEL_LINES-1:0] = imr;
				EEL_OFS_EMR:  next_rd_data[EEL_LINES-1:0] = emr;
				EEL_OFS_RTSR: next_rd_data[EEL_LINES-1:0] = rtsr;
				EEL_OFS_FTSR: next_rd_data[EEL_LINES-1:0] = ftsr;
				EEL_OFS_PEND: next_rd_data[EEL_LINES-1:0] = pend;
				default: begin
					for (int k = 0; k < EEL_SEL_REGS; k++) begin
						if (REQ.addr == EEL_OFS_SEL0 + 8'(k) * EEL_OFS_STEP)
						begin
							for (int m = 0; m < EEL_SEL_PER_REG; m++) begin
								next_rd_data[m*EEL_SEL_STRIDE +: EEL_SELW] =
									sel[k*EEL_SEL_PER_REG+m];
							end
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			rd_data <= EEL_RST_DATA;
		end else begin
			rd_data <= next_rd_data;
		end
	end

	// ========================================================================
	// outputs
	assign RD_DATA  = rd_data;
	assign OUT.irq  = pend & imr;
	assign OUT.evt  = evt;
	assign OUT.wake = wake;

	// ========================================================================
	// checks
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!RST_B);

	a_irq_raise: assert property (
		(trig & imr) != '0 |=>
		(OUT.irq & $past(trig & imr)) == $past(trig & imr))
		else $error("selected edge did not raise interrupt");

	a_wake_req: assert property (
		(hit & (imr | emr)) != '0 |=> OUT.wake)
		else $error("enabled edge gave no wake request");

	a_wake_quiet: assert property (
		(hit & (imr | emr)) == '0 |=> !OUT.wake)
		else $error("wake request without enabled edge");

	a_trig_select: assert property (
		(line_rise & ~rtsr & ~(line_fall & ftsr) & ~sw_trig & ~pend
			& imr) != '0 |=>
		(pend & $past(line_rise & ~rtsr & ~(line_fall & ftsr)
			& ~sw_trig & ~pend)) == '0)
		else $error("unselected edge set pending");

	a_mask_pend: assert property (
		1'b1 |=> (pend & ~$past(pend) & ~$past(imr)) == '0)
		else $error("masked line set pending");

	a_mask_event: assert property (
		1'b1 |=> (OUT.evt & ~$past(emr)) == '0)
		else $error("masked line gave an event");

	a_read_pend: assert property (
		REQ.rd && REQ.addr == EEL_OFS_PEND |=>
		RD_DATA[EEL_LINES-1:0] == $past(pend))
		else $error("pending read mismatch");

	a_pend_sticky: assert property (
		1'b1 |=> (~pend & $past(pend & ~pend_clr)) == '0)
		else $error("pending dropped without clear");

	a_pend_clear: assert property (
		pend_clr != '0 |=> (pend & $past(pend_clr & ~(hit & imr))) == '0)
		else $error("pending not cleared by write");

	c_irq_rise: cover property ((line_rise & rtsr & imr) != '0 ##1
		OUT.irq != '0);
	c_both_edges: cover property ((line_rise & rtsr) != '0 ##[1:20]
		(line_fall & ftsr) != '0);
	c_clear: cover property (pend != '0 ##1 pend_clr != '0 ##1 pend == '0);
	c_set_and_clear: cover property ((pend_clr & hit & imr) != '0);

endmodule : eel_extended_line_event_unit

// file: dv/eel_src_model.sv
`timescale 1ns/10ps
// ============================================================================
// pin and peripheral event sources standing beside the unit
module eel_src_model
	import eel_pkg::*;
#(
	parameter int unsigned N_PINS = EEL_PINS
)(
	input  wire logic                CORE_CLK,
	output logic      [N_PINS-1:0]   PINS,
	output logic      [EEL_INT-1:0]  PERIPH_EVT
);
	// pins rest low; this model drives them low from time zero
	initial begin
		PINS       = '0;
		PERIPH_EVT = '0;
	end

	// glitch narrower than a clock period, placed off any clock edge
	task automatic glitch(input int idx, input int w_ns);
		#3;
		PINS[idx] = 1'b1;
		#(w_ns);
		PINS[idx] = 1'b0;
	endtask : glitch

	// peripheral levels are clock-synchronous, so they move after an edge
	task automatic level(input int idx, input logic v);
		@(posedge CORE_CLK);
		PERIPH_EVT[idx] <= v;
	endtask : level
endmodule : eel_src_model

// file: dv/tb_top.sv
`timescale 1ns/10ps
module tb_top
	import eel_pkg::*;
;
	// ========================================================================
	// design, sources and the reference model state
	logic                core_clk;
	logic                rst_b;
	eel_req_t            req;
	logic     [31:0]     rd_data;
	logic     [54:0]     pins;
	logic     [7:0]      periph_evt;
	eel_out_t            out_s;
	logic     [23:0]     imr, emr, rt, ft, pend, exp_evt, evt_acc;
	int                  n_fail, n_compared, exp_wake, wake_cnt, p, e;
	int                  seed = 51102;
	logic     [31:0]     rst_q[$];

	eel_extended_line_event_unit dut (
		.CORE_CLK   (core_clk),
		.RST_B      (rst_b),
		.REQ        (req),
		.RD_DATA    (rd_data),
		.PINS       (pins),
		.PERIPH_EVT (periph_evt),
		.OUT        (out_s)
	);

	eel_src_model src (
		.CORE_CLK   (core_clk),
		.PINS       (pins),
		.PERIPH_EVT (periph_evt)
	);

	// free-running 100 MHz clock
	initial core_clk = 1'b0;
	always #5 core_clk = ~core_clk;

	// pulses are accumulated so a one-cycle output cannot slip past
	always @(negedge core_clk) begin
		evt_acc |= out_s.evt;
		// an unknown wake counts as a pulse, so it cannot hide in a zero
		if (out_s.wake !== 1'b0) wake_cnt++;
	end

	// ========================================================================
	// compare, bus and model tasks
	task automatic chk(input string what, input logic [31:0] x, y);
		n_compared++;
		if (y !== x) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", what, x, y);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		req.addr  <= a;
		req.wdata <= d;
		req.wr    <= 1'b1;
		@(posedge core_clk);
		req.wr    <= 1'b0;
	endtask : wr

	// read data stand only in the cycle after the strobe
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] x);
		@(posedge core_clk);
		req.addr <= a;
		req.rd   <= 1'b1;
		@(posedge core_clk);
		req.rd   <= 1'b0;
		@(negedge core_clk);
		chk($sformatf("reg %h", a), x, rd_data);
	endtask : rd_chk

	task automatic cfg(input logic [23:0] i, m, r, f);
		imr = i;
		emr = m;
		rt  = r;
		ft  = f;
		wr(EEL_OFS_IMR, {8'h00, i});
		wr(EEL_OFS_EMR, {8'h00, m});
		wr(EEL_OFS_RTSR, {8'h00, r});
		wr(EEL_OFS_FTSR, {8'h00, f});
	endtask : cfg

	task automatic arm();
		@(posedge core_clk);
		evt_acc  = '0;
		wake_cnt = 0;
		exp_evt  = '0;
		exp_wake = 0;
	endtask : arm

	// reference: a qualified or software edge on line l
	task automatic hit(input int l, input bit r, f, s);
		if (s || (r && rt[l]) || (f && ft[l])) begin
			if (imr[l]) pend[l] = 1'b1;
			if (emr[l]) exp_evt[l] = 1'b1;
			if (imr[l] || emr[l]) exp_wake++;
		end
	endtask : hit

	task automatic settle_chk(input string name);
		repeat (10) @(posedge core_clk);
		chk("irq", {8'h00, pend & imr}, {8'h00, out_s.irq});
		chk("evt", {8'h00, exp_evt}, {8'h00, evt_acc});
		chk("wake", 32'(exp_wake), 32'(wake_cnt));
		rd_chk(EEL_OFS_PEND, {8'h00, pend});
		$display("test %s done", name);
		arm();
	endtask : settle_chk

	task automatic end_of_test();
		$display("compared %0d mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : end_of_test

	// a hang is cut short well beyond the expected run time
	initial begin
		repeat (20000) @(posedge core_clk);
		n_fail++;
		end_of_test();
	end

	// ========================================================================
	// main sequence
	initial begin
		rst_b = 1'b0;
		req   = '0;
		pend  = '0;
		repeat (20) @(posedge core_clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge core_clk);
		// reset values, selectors start as line j on pin j
		for (int k = 0; k < 6; k++) rst_q.push_back(32'h0000_0000);
		for (int k = 0; k < 4; k++) begin
			e = 0;
			for (int m = 0; m < 4; m++) e |= (4 * k + m) << (8 * m);
			rst_q.push_back(32'(e));
		end
		for (int k = 0; k < 10; k++) rd_chk(8'(4 * k), rst_q[k]);
		rd_chk(8'h40, 32'h0000_0000);
		// random masks and triggers read back per line
		cfg(24'($random(seed)), 24'($random(seed)), 24'($random(seed)),
			24'($random(seed)));
		rd_chk(EEL_OFS_IMR, {8'h00, imr});
		rd_chk(EEL_OFS_EMR, {8'h00, emr});
		rd_chk(EEL_OFS_RTSR, {8'h00, rt});
		rd_chk(EEL_OFS_FTSR, {8'h00, ft});
		$display("test registers done");
		// rising, falling and both on peripheral lines; pending is sticky
		for (int md = 0; md < 3; md++) begin
			cfg(24'h1 << (16 + md), 24'h1 << (16 + md),
				md != 1 ? 24'h1 << (16 + md) : 24'h0,
				md != 0 ? 24'h1 << (16 + md) : 24'h0);
			arm();
			src.level(md, 1'b1);
			hit(16 + md, 1'b1, 1'b0, 1'b0);
			settle_chk("edge rise");
			src.level(md, 1'b0);
			hit(16 + md, 1'b0, 1'b1, 1'b0);
			settle_chk("edge fall");
			wr(EEL_OFS_PEND, {8'h00, pend});
			pend = '0;
			settle_chk("clear");
		end
		// one masked line beside an enabled one
		cfg(24'h40_0000, 24'h00_0000, 24'h60_0000, 24'h00_0000);
		src.level(5, 1'b1);
		src.level(6, 1'b1);
		hit(21, 1'b1, 1'b0, 1'b0);
		hit(22, 1'b1, 1'b0, 1'b0);
		settle_chk("mask");
		cfg(24'h00_0000, 24'h00_0000, 24'h60_0000, 24'h00_0000);
		settle_chk("mask pending");
		// software trigger on an external line
		cfg(24'h00_0020, 24'h00_0020, 24'h00_0000, 24'h00_0000);
		wr(EEL_OFS_SWTR, 32'h0000_0020);
		hit(5, 1'b0, 1'b0, 1'b1);
		settle_chk("soft");
		// a short glitch on a random pin routed to line 0
		p = 1 + (($random(seed) & 32'h7fff_ffff) % 54);
		wr(EEL_OFS_SEL0, 32'h3f3f_3f00 | 32'(p));
		rd_chk(EEL_OFS_SEL0, 32'h3f3f_3f00 | 32'(p));
		// last selector register, with the first value past the last pin
		wr(EEL_OFS_SEL0 + 8'h0C, 32'h3f3f_3f37);
		rd_chk(EEL_OFS_SEL0 + 8'h0C, 32'h3f3f_3f37);
		cfg(24'h00_0001, 24'h00_0001, 24'h00_0001, 24'h00_0000);
		src.glitch(p, 3);
		hit(0, 1'b1, 1'b0, 1'b0);
		settle_chk("glitch");
		src.glitch(0, 3);
		settle_chk("unrouted pin");
		end_of_test();
	end
endmodule : tb_top
